// ==== rtl/sram_boundary_scan_tap.sv ====
// boundary-scan test access port of a synchronous memory: controller,
// instruction, bypass, identification and boundary registers.
// assumes clk_i runs well above the test clock, which arrives as a pin.
// How it works
// RULE_01 - test inputs are taken at each rising test-clock edge.
// RULE_02 - the serial output changes only at a falling test-clock edge.
// RULE_03 - the mode-select level steers the controller at every rising edge.
// RULE_04 - the serial path is picked from controller state and held instruction.
// RULE_05 - there is no test reset pin; reset comes from mode-select or power-up.
// RULE_06 - five rising edges with mode-select high land in test-logic-reset.
// RULE_07 - power-up (system reset) resets the controller.
// RULE_08 - the identification instruction is loaded on power-up and in test-logic-reset.
// RULE_09 - the instruction loads only through the shift path and applies from update onward.
// RULE_10 - a one-bit bypass register can sit in the serial path.
// RULE_11 - under the identification instruction capture loads the 32-bit code.
// RULE_12 - the identification register shifts between data in and out in shift-DR.
// RULE_13 - the boundary register captures the I/O ring and then shifts it.
// RULE_14 - each boundary cell maps to one fixed bump in exit order.
// RULE_15 - under external test, output cells drive their updated values from update-IR.
// RULE_16 - the standard sixteen-state controller, registers update in update states.
// RULE_17 - unknown codes pick bypass, and bypass captures zero.
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap #(
    parameter int BSR_W = tap_pkg::BSR_LEN
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tdi_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_n_o,
    input  wire logic [BSR_W-1:0] ring_in_i,
    output logic      [BSR_W-1:0] ring_out_o,
    output logic                  ring_drive_o
);
    // RULE_05 no test reset pin exists; only resetn_i and the mode pattern

    tap_pkg::tap_pins_t pins_raw;
    tap_pkg::tap_pins_t pins_s;
    logic               tck_d_r;
    logic               tck_d_nxt;
    logic               rise;
    logic               fall;

    assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i};

    tap_sync #(.WIDTH(3)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (pins_raw),
        .q_o      (pins_s)
    );

    // edge finder on the synchronised test clock
    assign tck_d_nxt = pins_s.tck;
    assign rise      = pins_s.tck & ~tck_d_r;
    assign fall      = ~pins_s.tck & tck_d_r;

    tap_pkg::tap_state_t    state_r;
    tap_pkg::tap_state_t    state_nxt;
    logic [2:0]             ir_sh_r;
    logic [2:0]             ir_sh_nxt;
    logic [2:0]             ir_r;
    logic [2:0]             ir_nxt;
    logic                   byp_r;
    logic                   byp_nxt;
    logic [31:0]            id_r;
    logic [31:0]            id_nxt;
    logic [BSR_W-1:0]       bsr_r;
    logic [BSR_W-1:0]       bsr_nxt;
    logic [BSR_W-1:0]       upd_r;
    logic [BSR_W-1:0]       upd_nxt;
    logic                   drive_r;
    logic                   drive_nxt;
    logic                   tdo_r;
    logic                   tdo_nxt;
    logic                   oe_n_r;
    logic                   oe_n_nxt;
    logic                   tdo_pend;
    logic                   sel_id;
    logic                   sel_bsr;

    // RULE_17 unknown codes fall back to bypass
    assign sel_id  = (ir_r == tap_pkg::INS_IDCODE);
    assign sel_bsr = (ir_r == tap_pkg::INS_EXTEST) || (ir_r == tap_pkg::INS_SAMPLE);

    // controller next state
    always_comb begin
        state_nxt = state_r;
        if (rise) begin
            // RULE_03 RULE_16 standard state walk
            // RULE_06 five highs reach reset from any state
            case (state_r)
                tap_pkg::ST_RESET:    state_nxt = pins_s.tms ? tap_pkg::ST_RESET   : tap_pkg::ST_IDLE;
                tap_pkg::ST_IDLE:     state_nxt = pins_s.tms ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_DR:   state_nxt = pins_s.tms ? tap_pkg::ST_SEL_IR  : tap_pkg::ST_CAP_DR;
                tap_pkg::ST_CAP_DR:   state_nxt = pins_s.tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
                tap_pkg::ST_SHIFT_DR: state_nxt = pins_s.tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
                tap_pkg::ST_EXIT1_DR: state_nxt = pins_s.tms ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_PAUSE_DR;
                tap_pkg::ST_PAUSE_DR: state_nxt = pins_s.tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
                tap_pkg::ST_EXIT2_DR: state_nxt = pins_s.tms ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_SHIFT_DR;
                tap_pkg::ST_UPD_DR:   state_nxt = pins_s.tms ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_IR:   state_nxt = pins_s.tms ? tap_pkg::ST_RESET   : tap_pkg::ST_CAP_IR;
                tap_pkg::ST_CAP_IR:   state_nxt = pins_s.tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
                tap_pkg::ST_SHIFT_IR: state_nxt = pins_s.tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
                tap_pkg::ST_EXIT1_IR: state_nxt = pins_s.tms ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_PAUSE_IR;
                tap_pkg::ST_PAUSE_IR: state_nxt = pins_s.tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
                tap_pkg::ST_EXIT2_IR: state_nxt = pins_s.tms ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_SHIFT_IR;
                tap_pkg::ST_UPD_IR:   state_nxt = pins_s.tms ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
                default:              state_nxt = tap_pkg::ST_RESET;
            endcase
        end
    end

    // instruction path: shift stage and held instruction
    always_comb begin
        ir_sh_nxt = ir_sh_r;
        ir_nxt    = ir_r;
        drive_nxt = drive_r;
        if (rise) begin
            case (state_r)
                // RULE_08 default instruction in reset
                tap_pkg::ST_RESET: begin
                    ir_nxt    = tap_pkg::IR_RESET;
                    drive_nxt = 1'b0;
                end
                tap_pkg::ST_CAP_IR:   ir_sh_nxt = {1'b0, tap_pkg::IR_CAPTURE};
                // RULE_09 loaded only through the shift path
                tap_pkg::ST_SHIFT_IR: ir_sh_nxt = {pins_s.tdi, ir_sh_r[2:1]};
                // RULE_09 RULE_16 takes effect at update
                tap_pkg::ST_UPD_IR: begin
                    ir_nxt    = ir_sh_r;
                    // RULE_15 output drive turns on from update-IR
                    drive_nxt = (ir_sh_r == tap_pkg::INS_EXTEST);
                end
                default: ir_nxt = ir_r;
            endcase
            // RULE_08 default loaded on entry, not one edge later
            if (state_nxt == tap_pkg::ST_RESET) begin
                ir_nxt    = tap_pkg::IR_RESET;
                drive_nxt = 1'b0;
            end
        end
    end

    // data registers: bypass, identification, boundary
    always_comb begin
        byp_nxt = byp_r;
        id_nxt  = id_r;
        bsr_nxt = bsr_r;
        upd_nxt = upd_r;
        if (rise) begin
            case (state_r)
                tap_pkg::ST_CAP_DR: begin
                    // RULE_17 bypass captures zero
                    byp_nxt = 1'b0;
                    // RULE_11 identification code loaded
                    if (sel_id)
                        id_nxt = {tap_pkg::ID_REV, tap_pkg::ID_PART, tap_pkg::ID_VENDOR, tap_pkg::ID_FIX};
                    // RULE_13 boundary captures the ring
                    if (sel_bsr)
                        bsr_nxt = ring_in_i;
                end
                tap_pkg::ST_SHIFT_DR: begin
                    // RULE_01 data taken at the rising edge
                    // RULE_10 one-bit bypass stage
                    // RULE_12 identification shifts toward the output
                    // RULE_14 cell index = exit-order position minus one
                    if (sel_id)
                        id_nxt = {pins_s.tdi, id_r[31:1]};
                    else if (sel_bsr)
                        bsr_nxt = {pins_s.tdi, bsr_r[BSR_W-1:1]};
                    else
                        byp_nxt = pins_s.tdi;
                end
                tap_pkg::ST_UPD_DR: begin
                    // RULE_16 boundary update stage
                    if (sel_bsr)
                        upd_nxt = bsr_r;
                end
                default: byp_nxt = byp_r;
            endcase
        end
    end

    // RULE_04 serial path from state and instruction
    always_comb begin
        tdo_pend = byp_r;
        if (state_r == tap_pkg::ST_SHIFT_IR)
            tdo_pend = ir_sh_r[0];
        else if (sel_id)
            tdo_pend = id_r[0];
        else if (sel_bsr)
            tdo_pend = bsr_r[0];
    end

    // RULE_02 output changes only at the falling edge
    always_comb begin
        tdo_nxt  = tdo_r;
        oe_n_nxt = oe_n_r;
        if (fall) begin
            tdo_nxt  = tdo_pend;
            oe_n_nxt = !((state_r == tap_pkg::ST_SHIFT_DR) || (state_r == tap_pkg::ST_SHIFT_IR));
        end
    end

    // register everything; RULE_07 system reset is power-up
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tck_d_r <= 1'b0;
            state_r <= tap_pkg::ST_RESET;
            ir_sh_r <= '0;
            ir_r    <= tap_pkg::IR_RESET;
            drive_r <= 1'b0;
            byp_r   <= 1'b0;
            id_r    <= '0;
            bsr_r   <= '0;
            upd_r   <= '0;
            tdo_r   <= 1'b0;
            oe_n_r  <= 1'b1;
        end else begin
            tck_d_r <= tck_d_nxt;
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r    <= ir_nxt;
            drive_r <= drive_nxt;
            byp_r   <= byp_nxt;
            id_r    <= id_nxt;
            bsr_r   <= bsr_nxt;
            upd_r   <= upd_nxt;
            tdo_r   <= tdo_nxt;
            oe_n_r  <= oe_n_nxt;
        end
    end

    assign tdo_o        = tdo_r;
    assign tdo_oe_n_o   = oe_n_r;
    assign ring_out_o   = upd_r;
    assign ring_drive_o = drive_r;
endmodule : sram_boundary_scan_tap
`default_nettype wire

// ==== inc/tap_pkg.sv ====
// package for the memory boundary-scan test port: controller states,
// instruction codes, register sizes and reset values.
// assumes a single system clock that oversamples the test clock.
package tap_pkg;

    // register sizes
    localparam int IR_LEN    = 3;
    localparam int ID_LEN    = 32;
    localparam int BSR_LEN   = 107;
    localparam int TLR_HIGHS = 5;

    // instruction codes (3-bit register)
    localparam logic [2:0] INS_EXTEST  = 3'h0;
    localparam logic [2:0] INS_IDCODE  = 3'h1;
    localparam logic [2:0] INS_SAMPLE  = 3'h4;
    localparam logic [2:0] INS_BYPASS  = 3'h7;
    localparam logic [2:0] IR_RESET    = INS_IDCODE;
    localparam logic [1:0] IR_CAPTURE  = 2'h1;

    // identification word fields; vendor and part values are arbitrary
    localparam logic [3:0]  ID_REV     = 4'h0;
    localparam logic [15:0] ID_PART    = 16'h0ABC;
    localparam logic [10:0] ID_VENDOR  = 11'h2A5;
    localparam logic        ID_FIX     = 1'h1;

    // sixteen controller states
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h3,
        ST_CAP_DR     = 4'h2,
        ST_SHIFT_DR   = 4'h6,
        ST_EXIT1_DR   = 4'h7,
        ST_PAUSE_DR   = 4'h5,
        ST_EXIT2_DR   = 4'h4,
        ST_UPD_DR     = 4'hC,
        ST_SEL_IR     = 4'hD,
        ST_CAP_IR     = 4'hF,
        ST_SHIFT_IR   = 4'hE,
        ST_EXIT1_IR   = 4'hA,
        ST_PAUSE_IR   = 4'hB,
        ST_EXIT2_IR   = 4'h9,
        ST_UPD_IR     = 4'h8
    } tap_state_t;

    // test pins as sampled inside the block
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

endpackage : tap_pkg

// ==== rtl/tap_sync.sv ====
// two-flop synchroniser for a bundle of test pins.
// assumes the pins are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tap_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // first stage feeds only the second
    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : tap_sync
`default_nettype wire

// ==== bench/scan_ctrl_model.sv ====
// external scan controller: drives test clock, mode select and data in.
// assumes one caller at a time; the test clock stands low between steps.
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // one 125 ns period; tdo read just before the rise, set by last fall
    // held around rise
    task step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #62.5;
        tdo = tdo_i;
        tck_o = 1'b1;
        #62.5;
        tck_o = 1'b0; // next step sets data in this same time step
    endtask : step
    task force_reset();
        logic d;
        repeat (5) step(1'b1, 1'b0, d);
    endtask : force_reset
endmodule : scan_ctrl_model
`default_nettype wire

// ==== bench/sram_boundary_scan_tap_properties.sv ====
// timing checks on the test port pins and boundary outputs.
// assumes the test clock is far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module tap_checker #(
    parameter int BSR_W = tap_pkg::BSR_LEN
) (
    input wire logic             clk_i,
    input wire logic             resetn_i,
    input wire logic             tck_i,
    input wire logic             tms_i,
    input wire logic             tdi_i,
    input wire logic             tdo_o,
    input wire logic             tdo_oe_n_o,
    input wire logic [BSR_W-1:0] ring_in_i,
    input wire logic [BSR_W-1:0] ring_out_o,
    input wire logic             ring_drive_o
);
    logic [2:0] tck_r, tck_nxt, highs_r, highs_nxt;
    logic [1:0] tms_r, tms_nxt;
    logic       last_r, last_nxt;
    // own copy of the pin sync, counting mode-select highs per rise
    always_comb begin
        tck_nxt = {tck_r[1:0], tck_i};
        tms_nxt = {tms_r[0], tms_i};
        highs_nxt = highs_r;
        last_nxt = last_r;
        if (tck_r[1] && !tck_r[2]) begin
            last_nxt = tms_r[1];
            highs_nxt = !tms_r[1] ? 3'h0 : (highs_r == 3'h5 ? 3'h5 : highs_r + 3'h1);
        end
        if (!resetn_i) begin
            highs_nxt = 3'h5; // power-up lands in reset too
            last_nxt = 1'b1;
        end
    end
    // registers only
    always_ff @(posedge clk_i) begin
        {tck_r, tms_r, highs_r, last_r} <= {tck_nxt, tms_nxt, highs_nxt, last_nxt};
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_quiet;
        ##[0:6] (!ring_drive_o && tdo_oe_n_o);
    endsequence
    chk_tdo_fall_only: assert property (tck_i && $past(tck_i) |-> $stable(tdo_o))
        else $error("tdo moved while tck high");
    chk_oe_fall_edge: assert property ($changed(tdo_oe_n_o) |-> !tck_i)
        else $error("tdo enable moved while tck high");
    chk_reset_state: assert property ($rose(resetn_i) |-> tdo_oe_n_o && !tdo_o && !ring_drive_o
        && ring_out_o == '0) else $error("bad state after power-up");
    chk_tms_reset: assert property (highs_r == 3'h5 |-> s_quiet)
        else $error("five tms highs did not reset");
    chk_reset_no_shift: assert property (highs_r == 3'h5 && tdo_oe_n_o |=> tdo_oe_n_o)
        else $error("tdo enabled in reset");
    chk_shift_needs_tms: assert property ($fell(tdo_oe_n_o) |-> !last_r)
        else $error("shift entered with tms high");
    chk_drive_on_rise: assert property ($changed(ring_drive_o) |-> tck_i)
        else $error("drive moved off a rise");
    chk_update_on_rise: assert property ($changed(ring_out_o) |-> tck_i)
        else $error("ring update off a rise");
endmodule : tap_checker
bind sram_boundary_scan_tap tap_checker #(.BSR_W(BSR_W)) u_tap_checker (.clk_i(clk_i), .resetn_i(resetn_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .ring_in_i(ring_in_i), .ring_out_o(ring_out_o), .ring_drive_o(ring_drive_o));
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the boundary-scan port.
// assumes the scan controller model paces all test-clock traffic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int W = tap_pkg::BSR_LEN;
    localparam logic [31:0] ID = {tap_pkg::ID_REV, tap_pkg::ID_PART, tap_pkg::ID_VENDOR, tap_pkg::ID_FIX};
    localparam logic [W-1:0] P = W'(128'h0123456789ABCDEF0F1E2D3C4B5A6978);
    localparam logic [W-1:0] NP = ~P; // kept at ring width, no sign-extended ones
    logic         clk_i = 1'b0;
    logic         resetn_i, tck, tms, tdi, tdo, oe_n, drive, d;
    logic [W-1:0] ring_in, ring_out;
    int           n_mismatch = 0;
    int           n_tests = 0;
    int           cycles = 0;
    always #4 clk_i = ~clk_i;
    sram_boundary_scan_tap #(.BSR_W(W)) u_sram_boundary_scan_tap (.clk_i(clk_i), .resetn_i(resetn_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(oe_n), .ring_in_i(ring_in),
        .ring_out_o(ring_out), .ring_drive_o(drive));
    scan_ctrl_model u_scan_ctrl_model (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
    task check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // idle -> capture -> shift n bits lsb first -> update -> idle, then compare
    task scan(input logic ir, input int n, input logic [127:0] din, input logic [127:0] exp);
        logic [127:0] q;
        q = '0;
        u_scan_ctrl_model.step(1'b1, 1'b0, d);
        if (ir) u_scan_ctrl_model.step(1'b1, 1'b0, d);
        u_scan_ctrl_model.step(1'b0, 1'b0, d);
        u_scan_ctrl_model.step(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) u_scan_ctrl_model.step(i == n - 1, din[i], q[i]);
        u_scan_ctrl_model.step(1'b1, 1'b0, d);
        u_scan_ctrl_model.step(1'b0, 1'b0, d);
        check(q, exp);
    endtask : scan
    task t_codes();
        for (int c = 0; c < 8; c++) begin
            scan(1'b1, 3, c, 3'h1);
            if (3'(c) == tap_pkg::INS_IDCODE) scan(1'b0, 32, 0, ID);
            else if (c != 0 && c != 4) scan(1'b0, 8, 8'hA5, 8'h4A);
            check(drive, 3'(c) == tap_pkg::INS_EXTEST);
        end
        $display("codes done");
    endtask : t_codes
    task t_boundary();
        @(negedge clk_i) ring_in = P;
        scan(1'b1, 3, tap_pkg::INS_SAMPLE, 3'h1);
        scan(1'b0, W, NP, P);
        check(ring_out, NP);
        scan(1'b1, 3, tap_pkg::INS_EXTEST, 3'h1);
        check(drive, 1'b1);
        $display("boundary done");
    endtask : t_boundary
    // abort a shift mid-way with mode-select highs
    task t_tms_reset();
        u_scan_ctrl_model.step(1'b1, 1'b0, d);
        repeat (5) u_scan_ctrl_model.step(1'b0, 1'b1, d);
        u_scan_ctrl_model.force_reset();
        u_scan_ctrl_model.step(1'b0, 1'b0, d);
        check(drive, 1'b0);
        scan(1'b0, 32, 0, ID);
        $display("tms reset done");
    endtask : t_tms_reset
    task t_power();
        scan(1'b1, 3, tap_pkg::INS_BYPASS, 3'h1);
        @(negedge clk_i) resetn_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check(oe_n, 1'b1);
        resetn_i = 1'b1;
        u_scan_ctrl_model.step(1'b0, 1'b0, d);
        scan(1'b0, 32, 0, ID);
        $display("power reset done");
    endtask : t_power
    // hang guard, run needs about 6900 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        resetn_i = 1'b0;
        ring_in = '0;
        d = 1'b0;
        repeat (16) @(negedge clk_i);
        resetn_i = 1'b1;
        u_scan_ctrl_model.step(1'b0, 1'b0, d);
        scan(1'b0, 32, 0, ID);
        t_codes();
        t_boundary();
        t_tms_reset();
        t_power();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
